// >>> hw/srs_result_regs.sv
// sensor result, mailbox, power status and key register slice
`timescale 1ns/1ps
module srs_result_regs (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire srs_pkg::srs_req_t i_req,
  input wire srs_pkg::srs_meas_t i_meas,
  input wire srs_pkg::srs_param_t i_param,
  input wire srs_pkg::srs_pwr_t i_pwr_state,
  input wire logic i_uv_channel_select,
  input wire logic [7:0] i_irq_status,
  input wire logic [7:0] i_irq_enable,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_int_n
);
  import srs_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  srs_state_t state_reg;
  srs_state_t state_next;
  logic [7:0] status_byte;
  logic [7:0] read_mux;
  logic [15:0] aux_src;

  // reserved bits tied low, read-only so host writes have no path here
  always_comb begin
    status_byte = 8'h00; // [R10]
    unique case (i_pwr_state)
      SRS_PWR_RUNNING: status_byte[SRS_STAT_RUNNING_BIT] = 1'b1; // [R4]
      SRS_PWR_SUSPEND: status_byte[SRS_STAT_SUSPEND_BIT] = 1'b1; // [R4]
      SRS_PWR_SLEEP: status_byte[SRS_STAT_SLEEP_BIT] = 1'b1; // [R5]
      default: status_byte = 8'h00;
    endcase
  end

  // parameter memory lives behind the command path; any address not listed reads zero
  always_comb begin
    unique case (i_req.addr)
      SRS_IR_RESULT_HIGH_BYTE: read_mux = state_reg.ir_hi; // [R2]
      SRS_AUX_RESULT_LOW_BYTE: read_mux = state_reg.aux_lo; // [R2]
      SRS_AUX_RESULT_HIGH_BYTE: read_mux = state_reg.aux_hi; // [R2]
      SRS_PARAMETER_READBACK_MAILBOX: read_mux = state_reg.mailbox; // [R3]
      SRS_POWER_STATE_STATUS: read_mux = status_byte; // [R4]
      SRS_KEY_BYTE3: read_mux = state_reg.key[31:24];
      SRS_KEY_BYTE2: read_mux = state_reg.key[23:16];
      SRS_KEY_BYTE1: read_mux = state_reg.key[15:8];
      SRS_KEY_BYTE0: read_mux = state_reg.key[7:0];
      default: read_mux = SRS_UNMAPPED_READ; // [R6]
    endcase
  end

  assign aux_src = i_uv_channel_select ? i_meas.uv : i_meas.aux; // [R9]

  always_comb begin
    state_next = state_reg;
    state_next.rvalid = i_req.rd;
    if (i_req.rd) begin
      state_next.rdata = read_mux;
    end
    if (i_req.wr) begin
      unique case (i_req.addr)
        SRS_IR_RESULT_HIGH_BYTE: state_next.ir_hi = i_req.wdata;
        SRS_AUX_RESULT_LOW_BYTE: state_next.aux_lo = i_req.wdata;
        SRS_AUX_RESULT_HIGH_BYTE: state_next.aux_hi = i_req.wdata;
        SRS_PARAMETER_READBACK_MAILBOX: state_next.mailbox = i_req.wdata;
        SRS_KEY_BYTE3: state_next.key[31:24] = i_req.wdata;
        SRS_KEY_BYTE2: state_next.key[23:16] = i_req.wdata;
        SRS_KEY_BYTE1: state_next.key[15:8] = i_req.wdata;
        SRS_KEY_BYTE0: state_next.key[7:0] = i_req.wdata;
        default: state_next.key = state_reg.key; // [R10]
      endcase
    end
    // hardware update wins over a same-cycle host write; an unread result is lost here
    if (i_meas.valid) begin
      state_next.ir_hi = i_meas.ir[15:8]; // [R2]
      state_next.aux_lo = aux_src[7:0]; // [R9]
      state_next.aux_hi = aux_src[15:8]; // [R9]
    end
    if (i_param.valid) begin
      state_next.mailbox = i_param.value; // [R3]
    end
    state_next.int_n = ~|(i_irq_status & i_irq_enable); // [R8]
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{ir_hi: SRS_BYTE_RESET, aux_lo: SRS_BYTE_RESET, aux_hi: SRS_BYTE_RESET,
                     mailbox: SRS_BYTE_RESET, key: SRS_KEY_RESET, rdata: SRS_BYTE_RESET,
                     rvalid: 1'b0, int_n: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata = state_reg.rdata;
  assign o_rvalid = state_reg.rvalid;
  assign o_int_n = state_reg.int_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // measurement and mailbox stores
  // ----------------------------------------------------------------
  a_aux_uv_store: assert property (i_meas.valid && i_uv_channel_select |=> // [R9]
    state_reg.aux_lo == $past(i_meas.uv[7:0]) && state_reg.aux_hi == $past(i_meas.uv[15:8]))
    else $error("uv result not placed in aux bytes");
  a_aux_plain_store: assert property (i_meas.valid && !i_uv_channel_select |=> // [R2]
    {state_reg.aux_hi, state_reg.aux_lo} == $past(i_meas.aux))
    else $error("aux result not stored");
  a_ir_high_store: assert property (i_meas.valid |=> state_reg.ir_hi == $past(i_meas.ir[15:8])) // [R2]
    else $error("ir high byte not stored");
  a_mailbox_load: assert property (i_param.valid |=> state_reg.mailbox == $past(i_param.value)) // [R3]
    else $error("mailbox does not return parameter value");
  a_aux_low_write: assert property (i_req.wr && i_req.addr == SRS_AUX_RESULT_LOW_BYTE && // [R2]
    !i_meas.valid |=> state_reg.aux_lo == $past(i_req.wdata))
    else $error("host write to aux low byte lost");

  // ----------------------------------------------------------------
  // results stand until the next measurement or host write, the mailbox until the next parameter readback or host write
  // ----------------------------------------------------------------
  // same-cycle hardware updates are left out here; the store checks cover them
  a_ir_high_hold: assert property (!i_meas.valid && // [R2]
    !(i_req.wr && i_req.addr == SRS_IR_RESULT_HIGH_BYTE) |=> $stable(state_reg.ir_hi))
    else $error("ir high byte changed without cause");
  a_aux_hold: assert property (!i_meas.valid && // [R2]
    !(i_req.wr && (i_req.addr == SRS_AUX_RESULT_LOW_BYTE || i_req.addr == SRS_AUX_RESULT_HIGH_BYTE)) |=>
    $stable(state_reg.aux_lo) && $stable(state_reg.aux_hi))
    else $error("aux bytes changed without cause");
  a_mailbox_hold: assert property (!i_param.valid && // [R3]
    !(i_req.wr && i_req.addr == SRS_PARAMETER_READBACK_MAILBOX) |=> $stable(state_reg.mailbox))
    else $error("mailbox changed without cause");

  // ----------------------------------------------------------------
  // refused writes
  // ----------------------------------------------------------------
  a_status_ro_write: assert property (i_req.wr && i_req.addr == SRS_POWER_STATE_STATUS && // [R10]
    !i_meas.valid && !i_param.valid |=> $stable(state_reg.ir_hi) && $stable(state_reg.aux_lo) &&
    $stable(state_reg.aux_hi) && $stable(state_reg.mailbox) && $stable(state_reg.key))
    else $error("write to status register changed state");
  a_unmapped_write: assert property (i_req.wr && i_req.addr < SRS_IR_RESULT_HIGH_BYTE && // [R6]
    !i_meas.valid && !i_param.valid |=> $stable(state_reg.ir_hi) && $stable(state_reg.aux_lo) &&
    $stable(state_reg.aux_hi) && $stable(state_reg.mailbox) && $stable(state_reg.key))
    else $error("write below the register space changed state");

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  a_ir_high_read: assert property (i_req.rd && i_req.addr == SRS_IR_RESULT_HIGH_BYTE |=> // [R2]
    o_rvalid && o_rdata == $past(state_reg.ir_hi))
    else $error("ir high byte read wrong");
  a_aux_low_read: assert property (i_req.rd && i_req.addr == SRS_AUX_RESULT_LOW_BYTE |=> // [R2]
    o_rvalid && o_rdata == $past(state_reg.aux_lo))
    else $error("aux low byte read wrong");
  a_aux_high_read: assert property (i_req.rd && i_req.addr == SRS_AUX_RESULT_HIGH_BYTE |=> // [R2]
    o_rvalid && o_rdata == $past(state_reg.aux_hi))
    else $error("aux high byte read wrong");
  a_mailbox_read: assert property (i_req.rd && i_req.addr == SRS_PARAMETER_READBACK_MAILBOX |=> // [R3]
    o_rvalid && o_rdata == $past(state_reg.mailbox))
    else $error("mailbox read wrong");
  a_rvalid_follow: assert property (i_req.rd |=> o_rvalid) // [R2]
    else $error("read valid missing");
  a_rvalid_pulse: assert property (!i_req.rd |=> !o_rvalid) // [R2]
    else $error("read valid without a read");
  a_rdata_hold: assert property (!i_req.rd |=> $stable(o_rdata)) // [R2]
    else $error("read data changed without a read");

  // ----------------------------------------------------------------
  // status and unmapped reads
  // ----------------------------------------------------------------
  a_status_awake: assert property (i_req.rd && i_req.addr == SRS_POWER_STATE_STATUS && // [R4]
    i_pwr_state == SRS_PWR_RUNNING |=> o_rdata == 8'h04)
    else $error("awake status wrong");
  a_status_suspend: assert property (i_req.rd && i_req.addr == SRS_POWER_STATE_STATUS && // [R4]
    i_pwr_state == SRS_PWR_SUSPEND |=> o_rdata == 8'h02)
    else $error("suspend status wrong");
  a_status_sleep: assert property (i_req.rd && i_req.addr == SRS_POWER_STATE_STATUS && // [R5]
    i_pwr_state == SRS_PWR_SLEEP |=> o_rdata == 8'h01)
    else $error("sleep status wrong");
  a_status_rsvd: assert property (i_req.rd && i_req.addr == SRS_POWER_STATE_STATUS |=> // [R10]
    o_rdata[7:3] == 5'h00 && $onehot(o_rdata[2:0]))
    else $error("status reserved bits not zero");
  a_param_unmapped: assert property (i_req.rd && i_req.addr < SRS_IR_RESULT_HIGH_BYTE |=> // [R6]
    o_rdata == 8'h00)
    else $error("unmapped address returned data");

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  a_int_follow: assert property (|(i_irq_status & i_irq_enable) |=> !o_int_n) // [R8]
    else $error("interrupt not asserted");
  a_int_quiet: assert property (!(|(i_irq_status & i_irq_enable)) [*2] |=> o_int_n) // [R8]
    else $error("interrupt asserted without cause");

  // ----------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------
  c_uv_store: cover property (i_meas.valid && i_uv_channel_select);
  c_meas_then_read: cover property (i_meas.valid ##[1:20] (i_req.rd && i_req.addr == SRS_AUX_RESULT_HIGH_BYTE));
  c_status_write: cover property (i_req.wr && i_req.addr == SRS_POWER_STATE_STATUS);
  c_int_pulse: cover property (o_int_n ##1 !o_int_n ##[1:10] o_int_n);
  c_meas_write_clash: cover property (i_meas.valid && i_req.wr && i_req.addr == SRS_IR_RESULT_HIGH_BYTE);
endmodule

// >>> hw/srs_pkg.sv
// constants, types and carriers for the sensor result and status register slice
// What the document requires of this block and of its host
// [R1] host reads each result byte after interrupt, before the next measurement completes
// [R2] results split low/high bytes: aux low 0x2C, aux high 0x2D, ir high 0x25
// [R3] 8-bit mailbox at 0x2E holds parameter values placed by the sequencer
// [R4] status at 0x30 is read-only; bit 2 awake, bit 1 waiting for measurement
// [R5] status bit 0 marks lowest-power state; bits 7 to 3 reserved
// [R6] parameter memory is never mapped into the directly addressed register space
// [R7] host touches parameters only through query and set commands
// [R8] interrupt output asserts when any status bit and its enable are both set
// [R9] with uv channel selected, uv result lands in the aux byte registers
// [R10] reserved status bits read zero; writes to read-only status are ignored
package srs_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SRS_IR_RESULT_HIGH_BYTE = 8'h25;
  localparam logic [7:0] SRS_AUX_RESULT_LOW_BYTE = 8'h2c;
  localparam logic [7:0] SRS_AUX_RESULT_HIGH_BYTE = 8'h2d;
  localparam logic [7:0] SRS_PARAMETER_READBACK_MAILBOX = 8'h2e;
  localparam logic [7:0] SRS_POWER_STATE_STATUS = 8'h30;
  localparam logic [7:0] SRS_KEY_BYTE3 = 8'h3b;
  localparam logic [7:0] SRS_KEY_BYTE2 = 8'h3c;
  localparam logic [7:0] SRS_KEY_BYTE1 = 8'h3d;
  localparam logic [7:0] SRS_KEY_BYTE0 = 8'h3e;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int SRS_STAT_RUNNING_BIT = 2;
  localparam int SRS_STAT_SUSPEND_BIT = 1;
  localparam int SRS_STAT_SLEEP_BIT = 0;
  localparam logic [7:0] SRS_BYTE_RESET = 8'h00;
  localparam logic [31:0] SRS_KEY_RESET = 32'h0000_0000;
  localparam logic [7:0] SRS_UNMAPPED_READ = 8'h00;

  typedef enum logic [1:0] {
    SRS_PWR_SLEEP,
    SRS_PWR_SUSPEND,
    SRS_PWR_RUNNING
  } srs_pwr_t;

  // register access from the serial front end, one byte per request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } srs_req_t;

  // measurement completion from the sequencer
  typedef struct packed {
    logic valid;
    logic [15:0] ir;
    logic [15:0] aux;
    logic [15:0] uv;
  } srs_meas_t;

  // parameter readback from the sequencer
  typedef struct packed {
    logic valid;
    logic [7:0] value;
  } srs_param_t;

  typedef struct packed {
    logic [7:0] ir_hi;
    logic [7:0] aux_lo;
    logic [7:0] aux_hi;
    logic [7:0] mailbox;
    logic [31:0] key;
    logic [7:0] rdata;
    logic rvalid;
    logic int_n;
  } srs_state_t;

endpackage

// >>> verif/srs_host_model.sv
// host-side model issuing byte register requests
`timescale 1ns/1ps
module srs_host_model (
  input wire logic i_clk,
  output srs_pkg::srs_req_t o_req
);
  import srs_pkg::*;
  initial o_req = '0;
  // ----------------------------------------------------------------
  // one byte access, held for exactly one taking edge
  // ----------------------------------------------------------------
  // direct addresses reach byte registers only; parameters go by command
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
    @(posedge i_clk);
    #1 o_req = '{rd: ~wr, wr: wr, addr: addr, wdata: wdata};
    @(posedge i_clk);
    // released lines show inverse, not the stale value
    #1 o_req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
  endtask
endmodule

// >>> verif/tb_srs_result_regs.sv
// self-checking bench for the result and status register slice
`timescale 1ns/1ps
module tb_srs_result_regs;
  import srs_pkg::*;
  typedef struct {logic [7:0] addr; logic [7:0] exp;} row_t;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  srs_req_t req;
  srs_meas_t meas = '0;
  srs_param_t param = '0;
  srs_pwr_t pwr = SRS_PWR_SLEEP;
  logic uv_sel = 1'b0;
  logic [7:0] irq_st = 8'h00;
  logic [7:0] irq_en = 8'h00;
  logic [7:0] rdata;
  logic rvalid;
  logic int_n;
  int err_total = 0;
  int n_compared = 0;
  row_t rows[8] = '{'{8'h25, 8'h12}, '{8'h2c, 8'h78}, '{8'h2d, 8'h56}, '{8'h2e, 8'ha5},
    '{8'h24, 8'h00}, '{8'h00, 8'h00}, '{8'h3b, 8'h00}, '{8'h30, 8'h01}};
  always #2 i_clk = ~i_clk;
  srs_host_model host (.i_clk(i_clk), .o_req(req));
  srs_result_regs dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(req), .i_meas(meas), .i_param(param),
    .i_pwr_state(pwr), .i_uv_channel_select(uv_sel), .i_irq_status(irq_st), .i_irq_enable(irq_en),
    .o_rdata(rdata), .o_rvalid(rvalid), .o_int_n(int_n));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host.access(1'b0, a, 8'h00);
    chk("rvalid", 8'h01, {7'h00, rvalid});
    chk("rdata", exp, rdata);
  endtask
  task automatic pulse(input logic [15:0] ir, input logic [15:0] aux, input logic [15:0] uv);
    @(posedge i_clk);
    #1 meas = '{valid: 1'b1, ir: ir, aux: aux, uv: uv};
    param = '{valid: 1'b1, value: 8'ha5};
    @(posedge i_clk);
    #1 meas = '0;
    param = '0;
  endtask
  task automatic settle(input srs_pwr_t p, input logic [7:0] en);
    @(posedge i_clk);
    #1 pwr = p;
    irq_en = en;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  // measurement and mailbox load land on the same edge as a host write
  task automatic clash(input logic [7:0] a);
    fork
      pulse(16'h4321, 16'h8765, 16'hfedc);
      host.access(1'b1, a, 8'hc3);
    join
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge i_clk);
    #1 i_nrst = 1'b1;
    repeat (3) @(posedge i_clk);
    rd(8'h2c, SRS_BYTE_RESET);
    pulse(16'h1234, 16'h5678, 16'h9abc);
    foreach (rows[i]) rd(rows[i].addr, rows[i].exp);
    host.access(1'b1, 8'h01, 8'h3c);
    rd(8'h01, 8'h00);
    host.access(1'b1, 8'h2c, 8'h3c);
    rd(8'h2c, 8'h3c);
    settle(SRS_PWR_RUNNING, 8'h00);
    rd(8'h30, 8'h04);
    settle(SRS_PWR_SUSPEND, 8'h00);
    rd(8'h30, 8'h02);
    host.access(1'b1, 8'h30, 8'hff);
    rd(8'h30, 8'h02);
    uv_sel = 1'b1;
    pulse(16'h1234, 16'h5678, 16'h9abc);
    rd(8'h2c, 8'hbc);
    rd(8'h2d, 8'h9a);
    host.access(1'b1, 8'h3e, 8'h5a);
    rd(8'h3e, 8'h5a);
    clash(8'h25);
    rd(8'h25, 8'h43);
    clash(8'h2e);
    rd(8'h2e, 8'ha5);
    irq_st = 8'h20;
    settle(SRS_PWR_RUNNING, 8'h20);
    chk("int_n", 8'h00, {7'h00, int_n});
    settle(SRS_PWR_RUNNING, 8'h10);
    chk("int_n", 8'h01, {7'h00, int_n});
    i_nrst = 1'b0;
    @(posedge i_clk);
    #1 chk("rdata", 8'h00, rdata);
    i_nrst = 1'b1;
    repeat (3) @(posedge i_clk);
    rd(8'h2d, SRS_BYTE_RESET);
    end_of_test();
  end
  // hang guard: a stuck run counts as a mismatch
  initial begin
    #100000;
    err_total++;
    end_of_test();
  end
endmodule
